//--- rtl/acr_pkg.sv
// Constants, types and register map of the converter control and result block
`default_nettype none
package acr_pkg;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] ACR_OFS_CTRL_A  = 8'h40;
   localparam logic [7:0] ACR_OFS_CTRL_B  = 8'h41;
   localparam logic [7:0] ACR_OFS_VBAT_H  = 8'h42;
   localparam logic [7:0] ACR_OFS_VBAT_L  = 8'h43;
   localparam logic [7:0] ACR_OFS_THERM_H = 8'h44;
   localparam logic [7:0] ACR_OFS_THERM_L = 8'h45;
   localparam logic [7:0] ACR_OFS_ICHG_H  = 8'h46;
   localparam logic [7:0] ACR_OFS_ICHG_L  = 8'h47;
   localparam logic [7:0] ACR_RST_CTRL_A  = 8'h02;
   localparam logic [7:0] ACR_RST_CTRL_B  = 8'h40;
   localparam logic [7:0] ACR_UNMAPPED    = 8'h00;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int ACR_RATE_MSB = 7;
   localparam int ACR_RATE_LSB = 6;
   localparam int ACR_TRIG_BIT = 5;
   localparam int ACR_TIME_MSB = 4;
   localparam int ACR_TIME_LSB = 3;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int ACR_CLK_HZ     = 40_000_000;
   localparam int ACR_CONV_MS    = 24;
   localparam int ACR_TICK_MS    = 3;
   localparam int ACR_TICK_CYC   = ACR_CLK_HZ / 1000 * ACR_TICK_MS;
   localparam int ACR_SEC_TICKS  = 1000 / ACR_TICK_MS + 1;
   localparam int ACR_MIN_SECS   = 60;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      ACR_RATE_MANUAL = 2'b00,
      ACR_RATE_CONT   = 2'b01,
      ACR_RATE_SEC    = 2'b10,
      ACR_RATE_MIN    = 2'b11
   } acr_rate_e;
   typedef enum logic [1:0] {
      ACR_ST_IDLE = 2'b00,
      ACR_ST_CONV = 2'b01,
      ACR_ST_DONE = 2'b10
   } acr_state_e;
   typedef struct packed {
      logic [15:0] vbat;
      logic [15:0] therm;
      logic [15:0] ichg;
   } acr_sample_s;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acr_req_s;
endpackage
`default_nettype wire

//--- rtl/acr_result_mem.sv
// Result store holding one 16-bit sample per channel, read data registered
`default_nettype none
module acr_result_mem
   import acr_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Write side
   input  wire logic        wr_en,
   input  wire acr_sample_s wr_data,
   // Read side
   input  wire logic [7:0]  rd_addr,
   output var  logic [7:0]  rd_data
);
   // Elaboration check: six result bytes must fit
   if (DEPTH < 6) begin : g_bad_depth
      $error("acr_result_mem: depth too small");
   end
   logic [7:0] mem_q [DEPTH];

   // Capture all bytes of a sample in the same cycle
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[0] <= wr_data.vbat[15:8];
         mem_q[1] <= wr_data.vbat[7:0];
         mem_q[2] <= wr_data.therm[15:8];
         mem_q[3] <= wr_data.therm[7:0];
         mem_q[4] <= wr_data.ichg[15:8];
         mem_q[5] <= wr_data.ichg[7:0];
      end
   end

   // Registered read port, index is offset above battery high byte
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_data <= ACR_UNMAPPED;
      end else if (rd_addr >= ACR_OFS_VBAT_H && rd_addr <= ACR_OFS_ICHG_L) begin
         rd_data <= mem_q[3'(rd_addr - ACR_OFS_VBAT_H)];
      end else begin
         rd_data <= ACR_UNMAPPED;
      end
   end
endmodule
`default_nettype wire

//--- rtl/acr_top.sv
// Converter control registers, scheduler and result register file
`default_nettype none
module acr_top
   import acr_pkg::*;
#(
   parameter int TICK_CYC = ACR_TICK_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Register port from the serial control logic
   input  wire acr_req_s    req,
   output var  logic [7:0]  rdata,
   // Converter data path
   input  wire logic        battery_only_operation,
   input  wire acr_sample_s sample,
   output var  logic        conv_busy,
   output var  logic [2:0]  alarm1_channel_select,
   output var  logic [2:0]  alarm2_channel_select,
   output var  logic [2:0]  alarm3_channel_select
);
   // Elaboration check: the tick divider needs a positive period
   if (TICK_CYC < 1) begin : g_bad_tick
      $error("acr_top: tick period must be positive");
   end

   // ***************************************************
   // Control registers
   // ***************************************************
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic       done_q;
   logic       batt_s1_q;
   logic       batt_q;

   // Control A with self-clearing trigger; a same-cycle host write wins so a new trigger is not lost
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_a_q <= ACR_RST_CTRL_A;
      end else begin
         if (done_q) begin
            ctrl_a_q[ACR_TRIG_BIT] <= 1'b0;
         end
         if (req.wr && req.addr == ACR_OFS_CTRL_A) begin
            ctrl_a_q <= req.wdata;
         end
      end
   end

   // Control B, reserved low bits kept read-write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_b_q <= ACR_RST_CTRL_B;
      end else if (req.wr && req.addr == ACR_OFS_CTRL_B) begin
         ctrl_b_q <= req.wdata;
      end
   end

   // Mode pin synchroniser; resets to battery-only so nothing starts before the pin is seen
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         batt_s1_q <= 1'b1;
         batt_q    <= 1'b1;
      end else begin
         batt_s1_q <= battery_only_operation;
         batt_q    <= batt_s1_q;
      end
   end

   // Alarm channel outputs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         alarm1_channel_select <= ACR_RST_CTRL_A[2:0];
         alarm2_channel_select <= ACR_RST_CTRL_B[7:5];
         alarm3_channel_select <= ACR_RST_CTRL_B[4:2];
      end else begin
         alarm1_channel_select <= ctrl_a_q[2:0];
         alarm2_channel_select <= ctrl_b_q[7:5];
         alarm3_channel_select <= ctrl_b_q[4:2];
      end
   end

   // ***************************************************
   // Time base: 3 ms ticks, seconds, minutes
   // ***************************************************
   logic [$clog2(TICK_CYC+1)-1:0] div_q;
   logic [8:0] tick_cnt_q;
   logic [5:0] sec_cnt_q;
   logic       tick_q;
   logic       sec_q;
   logic       min_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (32'(div_q) == TICK_CYC - 1);
         div_q  <= (32'(div_q) == TICK_CYC - 1) ? '0 : div_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt_q <= '0;
         sec_cnt_q  <= '0;
         sec_q      <= 1'b0;
         min_q      <= 1'b0;
      end else begin
         sec_q <= 1'b0;
         min_q <= 1'b0;
         if (tick_q) begin
            if (32'(tick_cnt_q) == ACR_SEC_TICKS - 1) begin
               tick_cnt_q <= '0;
               sec_q      <= 1'b1;
               if (32'(sec_cnt_q) == ACR_MIN_SECS - 1) begin
                  sec_cnt_q <= '0;
                  min_q     <= 1'b1;
               end else begin
                  sec_cnt_q <= sec_cnt_q + 1'b1;
               end
            end else begin
               tick_cnt_q <= tick_cnt_q + 1'b1;
            end
         end
      end
   end

   // ***************************************************
   // Conversion scheduler
   // ***************************************************
   function automatic logic [3:0] conv_ticks(input logic [1:0] sel);
      conv_ticks = 4'(ACR_CONV_MS / ACR_TICK_MS) >> sel; // 8,4,2,1 ticks
   endfunction

   acr_state_e state_q;
   logic [3:0] ticks_left_q;
   logic       start_ok;
   acr_rate_e  rate;

   always_comb begin
      rate = acr_rate_e'(ctrl_a_q[ACR_RATE_MSB:ACR_RATE_LSB]);
      if (!batt_q) begin
         start_ok = 1'b1; // Adapter present: convert continuously
      end else begin
         case (rate)
            ACR_RATE_MANUAL: start_ok = ctrl_a_q[ACR_TRIG_BIT];
            ACR_RATE_CONT:   start_ok = 1'b1;
            ACR_RATE_SEC:    start_ok = sec_q;
            ACR_RATE_MIN:    start_ok = min_q;
            default:         start_ok = 1'b0;
         endcase
      end
      if (ctrl_a_q[ACR_TRIG_BIT]) begin
         start_ok = 1'b1; // A manual request is always honoured
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q      <= ACR_ST_IDLE;
         ticks_left_q <= '0;
         done_q       <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ACR_ST_IDLE: begin
               if (start_ok) begin
                  state_q      <= ACR_ST_CONV;
                  ticks_left_q <= conv_ticks(ctrl_a_q[ACR_TIME_MSB:ACR_TIME_LSB]);
               end
            end
            ACR_ST_CONV: begin
               if (tick_q) begin
                  // One extra tick absorbs the partial first tick, so a conversion never runs short
                  if (ticks_left_q == 4'h0) begin
                     state_q <= ACR_ST_DONE;
                     done_q  <= 1'b1;
                  end else begin
                     ticks_left_q <= ticks_left_q - 1'b1;
                  end
               end
            end
            ACR_ST_DONE: state_q <= ACR_ST_IDLE;
            default:     state_q <= ACR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_busy <= 1'b0;
      end else begin
         conv_busy <= (state_q == ACR_ST_CONV);
      end
   end

   // ***************************************************
   // Read path
   // ***************************************************
   logic [7:0] res_rdata;
   logic [1:0] rsel_q;

   acr_result_mem #(.DEPTH(8)) u_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (done_q),
      .wr_data (sample),
      .rd_addr (req.addr),
      .rd_data (res_rdata)
   );

   // Select between control bytes and result store
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rsel_q <= 2'h0;
      end else begin
         rsel_q <= (req.addr == ACR_OFS_CTRL_A) ? 2'h1 : (req.addr == ACR_OFS_CTRL_B) ? 2'h2 : 2'h0;
      end
   end

   // Output register: answer stands two cycles after the address
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= ACR_UNMAPPED;
      end else begin
         case (rsel_q)
            2'h1:    rdata <= ctrl_a_q;
            2'h2:    rdata <= ctrl_b_q;
            default: rdata <= res_rdata;
         endcase
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   property p_trig_clear;
      @(posedge clk) disable iff (!reset_n)
      (done_q && !(req.wr && req.addr == ACR_OFS_CTRL_A && req.wdata[ACR_TRIG_BIT])) |=> !ctrl_a_q[ACR_TRIG_BIT];
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

   property p_manual_idle;
      @(posedge clk) disable iff (!reset_n)
      (state_q == ACR_ST_IDLE && batt_q && rate == ACR_RATE_MANUAL && !ctrl_a_q[ACR_TRIG_BIT])
         |=> state_q == ACR_ST_IDLE;
   endproperty
   a_manual_idle: assert property (p_manual_idle) else $error("manual mode started unasked");

   property p_reset_a;
      @(posedge clk) !reset_n |=> ctrl_a_q == ACR_RST_CTRL_A && ctrl_b_q == ACR_RST_CTRL_B;
   endproperty
   a_reset_a: assert property (p_reset_a) else $error("bad control reset");

   property p_wr_b;
      @(posedge clk) disable iff (!reset_n)
      (req.wr && req.addr == ACR_OFS_CTRL_B) |=> ##1 alarm2_channel_select == $past(req.wdata[7:5], 2);
   endproperty
   a_wr_b: assert property (p_wr_b) else $error("alarm 2 select not updated");

   property p_wr_a_alarm1;
      @(posedge clk) disable iff (!reset_n)
      (req.wr && req.addr == ACR_OFS_CTRL_A) |=> ##1 alarm1_channel_select == $past(req.wdata[2:0], 2);
   endproperty
   a_wr_a_alarm1: assert property (p_wr_a_alarm1) else $error("alarm 1 select not updated");

   property p_ctrl_b_hold;
      @(posedge clk) disable iff (!reset_n)
      !(req.wr && req.addr == ACR_OFS_CTRL_B) |=> $stable(ctrl_b_q);
   endproperty
   a_ctrl_b_hold: assert property (p_ctrl_b_hold) else $error("control B changed without a write");
endmodule
`default_nettype wire

//--- dv/acr_host_model.sv
// Host-side model driving the register port of the converter block
`default_nettype none
module acr_host_model
   import acr_pkg::*;
(
   // Clock and read data
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   // Register request
   output var  acr_req_s   req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // One write strobe, then an idle cycle before the next request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   // Checked read; the bench monitor collects the answer
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
   endtask
   // Hold the control address until the trigger reads back 0, bounded
   task automatic poll(output bit ok);
      ok = 1'b0;
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b0, addr: ACR_OFS_CTRL_A, wdata: 8'h00};
      for (int i = 0; i < 400 && !ok; i++) begin
         @(negedge clk);
         ok = (i > 0) && (rdata[ACR_TRIG_BIT] === 1'b0);
      end
      req = '0;
   endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the converter control and result block
`default_nettype none
module testbench
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   localparam int SEC = 334 * TK;
   logic        clk;
   logic        reset_n;
   logic        batt_only;
   acr_sample_s sample;
   acr_sample_s exp_s;
   acr_req_s    req;
   logic [7:0]  rdata;
   logic        conv_busy;
   logic [2:0]  al1, al2, al3;
   logic [7:0]  exp_q[$];
   logic [7:0]  v;
   logic [63:0] rnd;
   int          failures, n_checks, cyc, seed, n;
   bit          ok;
   acr_top #(.TICK_CYC(TK)) u_acr_top (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
      .battery_only_operation(batt_only), .sample(sample), .conv_busy(conv_busy),
      .alarm1_channel_select(al1), .alarm2_channel_select(al2), .alarm3_channel_select(al3));
   acr_host_model u_acr_host_model (.clk(clk), .rdata(rdata), .req(req));
   // ***************************************************
   // Helpers
   // ***************************************************
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Count falling edges until busy reaches a level or the limit runs out
   task automatic wait_busy(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (conv_busy !== lvl && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end
   // Read monitor: the oldest note is compared with each read answer
   always @(posedge clk) begin
      if (req.rd === 1'b1) begin
         repeat (2) @(negedge clk);
         chk(exp_q.pop_front(), rdata);
      end
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      reset_n = 1'b0;
      batt_only = 1'b1;
      sample = '0;
      seed = 46;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      exp_q.push_back(ACR_RST_CTRL_A);
      u_acr_host_model.rd(ACR_OFS_CTRL_A);
      exp_q.push_back(ACR_RST_CTRL_B);
      u_acr_host_model.rd(ACR_OFS_CTRL_B);
      chk(8'h02, {5'h00, al1});
      chk(8'h02, {5'h00, al2});
      chk(8'h00, {5'h00, al3});
      $display("end of reset test");
      for (int c = 0; c < 8; c++) begin
         v = 8'($random(seed));
         u_acr_host_model.wr(ACR_OFS_CTRL_A, {3'b000, v[4:3], c[2:0]});
         u_acr_host_model.wr(ACR_OFS_CTRL_B, v);
         exp_q.push_back({3'b000, v[4:3], c[2:0]});
         u_acr_host_model.rd(ACR_OFS_CTRL_A);
         exp_q.push_back(v);
         u_acr_host_model.rd(ACR_OFS_CTRL_B);
         chk({5'h00, c[2:0]}, {5'h00, al1});
         chk({5'h00, v[7:5]}, {5'h00, al2});
         chk({5'h00, v[4:2]}, {5'h00, al3});
      end
      $display("end of control field test");
      for (int s = 0; s < 4; s++) begin
         rnd = {$random(seed), $random(seed)};
         sample = rnd[47:0];
         exp_s = sample;
         u_acr_host_model.wr(ACR_OFS_CTRL_A, {3'b001, s[1:0], 3'b010});
         exp_q.push_back({3'b001, s[1:0], 3'b010});
         u_acr_host_model.rd(ACR_OFS_CTRL_A);
         wait_busy(1'b1, 20, n);
         wait_busy(1'b0, 100, n);
         chk(8'h01, {7'h00, n >= (8 >> s) * TK && n <= (8 >> s) * TK + TK + 3});
         u_acr_host_model.poll(ok);
         chk(8'h01, {7'h00, ok});
         sample = ~sample;
         for (int k = 0; k < 6; k++) begin
            v = exp_s[47 - 8 * k -: 8];
            u_acr_host_model.wr(ACR_OFS_VBAT_H + k[7:0], ~v);
            exp_q.push_back(v);
            u_acr_host_model.rd(ACR_OFS_VBAT_H + k[7:0]);
         end
      end
      u_acr_host_model.wr(ACR_UNMAPPED, 8'hff);
      exp_q.push_back(8'h00);
      u_acr_host_model.rd(ACR_UNMAPPED);
      $display("end of manual conversion test");
      wait_busy(1'b1, 200, n);
      chk(8'd200, n[7:0]);
      u_acr_host_model.wr(ACR_OFS_CTRL_A, 8'h5a);
      wait_busy(1'b1, 60, n);
      chk(8'h01, {7'h00, n < 60});
      u_acr_host_model.wr(ACR_OFS_CTRL_A, 8'h9a);
      wait_busy(1'b0, 100, n);
      wait_busy(1'b1, SEC + 100, n);
      wait_busy(1'b0, 100, n);
      wait_busy(1'b1, SEC + 100, n);
      chk(8'h01, {7'h00, n > SEC - 40 && n < SEC + 40});
      u_acr_host_model.wr(ACR_OFS_CTRL_A, 8'hda);
      wait_busy(1'b0, 100, n);
      wait_busy(1'b1, SEC + 100, n);
      wait_busy(1'b0, 100, n);
      wait_busy(1'b1, SEC + 100, n);
      chk(8'h01, {7'h00, n == SEC + 100});
      u_acr_host_model.wr(ACR_OFS_CTRL_A, 8'h1a);
      wait_busy(1'b0, 100, n);
      batt_only = 1'b0;
      wait_busy(1'b1, 60, n);
      chk(8'h01, {7'h00, n < 60});
      $display("end of schedule test");
      close_out();
   end
endmodule
`default_nettype wire
